// ### hw/cad_cfg.svh
// constants of the core arithmetic datapath
`ifndef CAD_CFG_SVH
`define CAD_CFG_SVH
`define CAD_W 16
`define CAD_AW 40
`define CAD_ADR_AAL 4'h0
`define CAD_ADR_AAH 4'h1
`define CAD_ADR_AAU 4'h2
`define CAD_ADR_ABL 4'h3
`define CAD_ADR_ABH 4'h4
`define CAD_ADR_ABU 4'h5
`define CAD_ADR_PSW 4'h6
`define CAD_ADR_CCW 4'h7
`define CAD_PSW_C 0
`define CAD_PSW_Z 1
`define CAD_PSW_OV 2
`define CAD_PSW_N 3
`define CAD_PSW_DC 8
`define CAD_PSW_SB 12
`define CAD_PSW_SA 13
`define CAD_PSW_OB 14
`define CAD_PSW_OA 15
`define CAD_CCW_IF 0
`define CAD_CCW_SATB 6
`define CAD_CCW_SATA 7
`define CAD_CCW_RST 16'h0000
`endif

// ### hw/cad_pkg.sv
// types of the core arithmetic datapath
package cad_pkg;
    typedef enum logic [3:0] {
        CAD_OP_ADD, CAD_OP_SUB, CAD_OP_AND, CAD_OP_IOR, CAD_OP_XOR,
        CAD_OP_SHL, CAD_OP_SHR, CAD_OP_ASR, CAD_OP_SE, CAD_OP_ZE,
        CAD_OP_MPY, CAD_OP_MAC, CAD_OP_MSC, CAD_OP_ACCADD, CAD_OP_SAC,
        CAD_OP_NOP
    } cad_op_t;
    typedef enum logic {CAD_ST_IDLE, CAD_ST_DSP} cad_state_t;
endpackage : cad_pkg

// ### hw/cad_datapath.sv
// integer unit, extension ops and signal-processing engine with accumulators
`timescale 1ns/1ps
`default_nettype none
`include "cad_cfg.svh"
////////////////////////////////////////////////////////////////////////////
// Contract
// RULE_01: 16-bit integer add, subtract, shift, logic
// RULE_02: integer arithmetic is two's complement
// RULE_03: integer ops update C Z N OV DC
// RULE_04: subtraction carry means no borrow
// RULE_05: byte or word width per instruction
// RULE_06: byte result writes low byte only
// RULE_07: byte flags come from low byte
// RULE_08: byte register ops keep upper byte
// RULE_09: sign extend byte into word
// RULE_10: zero extend clears upper eight bits
// RULE_11: engine never runs beside integer flow
// RULE_12: multiplier, shifter, 40-bit adder, two accumulators
// RULE_13: dual operands from registers four to seven
// RULE_14: other engine operands from X bus; here only the first, the second comes from OPB
// RULE_15: engine writes accumulator or X bus
// RULE_16: accumulator to accumulator operations supported
// RULE_17: integer shift and multiply use engine; shifts here are computed in the integer unit
// RULE_18: accumulators mapped as low, high, guard
// RULE_19: fractional point right of bit 31
// RULE_20: integer point right of bit 0
// RULE_21: mode bit set selects integer multiply
// RULE_22: adder pass updates accumulator overflow flag
// RULE_23: saturation flags sticky until software clear
// RULE_24: N is msb, Z is zero, at width
module cad_datapath #(
    parameter int W = `CAD_W,
    parameter int AW = `CAD_AW
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // instruction from decoder
    input wire logic OP_VALID,
    input wire cad_pkg::cad_op_t OP,
    input wire logic OP_BYTE,
    input wire logic OP_ACC_B,
    input wire logic OP_DUAL,
    input wire logic [W-1:0] OPA,
    input wire logic [W-1:0] OPB,
    input wire logic [W-1:0] OPDST,
    input wire logic [W-1:0] WREG4,
    input wire logic [W-1:0] WREG5,
    input wire logic [W-1:0] WREG6,
    input wire logic [W-1:0] WREG7,
    input wire logic [W-1:0] XBUS_IN,
    // results
    output logic RES_VALID,
    output logic [W-1:0] RES,
    output logic XBUS_WR,
    output logic [W-1:0] XBUS_OUT,
    output logic BUSY,
    // register port
    input wire logic [3:0] REG_ADDR,
    input wire logic [W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [W-1:0] REG_RDATA
);
    ////////////////////////////////////////////////////////////////////////
    // accumulator and status state
    logic [AW-1:0] acc_a;
    logic [AW-1:0] acc_b;
    logic [W-1:0] psw;
    logic [W-1:0] ccw;
    cad_pkg::cad_state_t state;

    // true when guard bits are not a sign extension of bit 31
    function automatic logic guard_ovf(input logic [AW-1:0] v);
        guard_ovf = !((&v[AW-1:31]) || !(|v[AW-1:31]));
    endfunction : guard_ovf

    // saturate a 41-bit sum to the 40-bit range
    function automatic logic [AW:0] sat40(input logic [AW:0] s);
        logic [AW:0] r;
        r = s;
        if (s[AW] != s[AW-1])
            r = {s[AW], s[AW], {(AW-1){~s[AW]}}};
        sat40 = r;
    endfunction : sat40

    ////////////////////////////////////////////////////////////////////////
    // integer unit, full 16-bit compute in both widths
    logic [W:0] alu_sum;
    logic [W-1:0] alu_res;
    logic [W-1:0] alu_wb;
    logic alu_c;
    logic alu_dc;
    logic alu_ov;
    logic alu_n;
    logic alu_z;
    logic alu_arith;
    logic alu_hit;
    logic [W-1:0] prod_lo;
    logic signed [33:0] mul_p;
    always_comb
    begin
        alu_sum = '0;
        alu_res = '0;
        alu_c = psw[`CAD_PSW_C];
        alu_dc = psw[`CAD_PSW_DC];
        alu_ov = psw[`CAD_PSW_OV];
        alu_arith = 1'b0;
        alu_hit = 1'b1;
        case (OP)
            cad_pkg::CAD_OP_ADD:
            begin
                alu_sum = {1'b0, OPA} + {1'b0, OPB}; // see RULE_01
                alu_arith = 1'b1;
            end
            cad_pkg::CAD_OP_SUB:
            begin
                alu_sum = {1'b0, OPA} + {1'b0, ~OPB} + 17'h00001; // see RULE_02
                alu_arith = 1'b1;
            end
            cad_pkg::CAD_OP_AND: alu_sum = {1'b0, OPA & OPB};
            cad_pkg::CAD_OP_IOR: alu_sum = {1'b0, OPA | OPB};
            cad_pkg::CAD_OP_XOR: alu_sum = {1'b0, OPA ^ OPB};
            // single-bit shifts are computed in the integer unit, not the engine's shifter path
            cad_pkg::CAD_OP_SHL: alu_sum = {OPA, 1'b0}; // see RULE_17
            cad_pkg::CAD_OP_SHR: alu_sum = {1'b0, 1'b0, OPA[W-1:1]};
            cad_pkg::CAD_OP_ASR: alu_sum = {1'b0, OPA[W-1], OPA[W-1:1]};
            // extensions set N and Z from the full word they produce in word mode, from its low byte in byte mode
            cad_pkg::CAD_OP_SE: alu_sum = {1'b0, {8{OPA[7]}}, OPA[7:0]};
            cad_pkg::CAD_OP_ZE: alu_sum = {1'b0, 8'h00, OPA[7:0]}; // see RULE_24
            default: alu_hit = 1'b0;
        endcase
        alu_res = alu_sum[W-1:0];
        // byte mode: flags only from the low byte
        if (OP_BYTE)
        begin
            alu_n = alu_res[7]; // see RULE_07
            alu_z = (alu_res[7:0] == 8'h00); // see RULE_24
        end
        else
        begin
            alu_n = alu_res[W-1];
            alu_z = (alu_res == 16'h0000);
        end
        if (alu_arith)
        begin
            // carry out of add; for subtract a set carry means no borrow
            alu_c = OP_BYTE ? (alu_res[8] ^ OPA[8] ^ (OP == cad_pkg::CAD_OP_SUB
                ? ~OPB[8] : OPB[8])) : alu_sum[W]; // see RULE_04
            alu_dc = OP_BYTE ? (alu_res[4] ^ OPA[4] ^ (OP == cad_pkg::CAD_OP_SUB
                ? ~OPB[4] : OPB[4])) : (alu_res[8] ^ OPA[8] ^
                (OP == cad_pkg::CAD_OP_SUB ? ~OPB[8] : OPB[8]));
            alu_ov = OP_BYTE
                ? ((OPA[7] == (OP == cad_pkg::CAD_OP_SUB ? ~OPB[7] : OPB[7]))
                   && (alu_res[7] != OPA[7]))
                : ((OPA[W-1] == (OP == cad_pkg::CAD_OP_SUB ? ~OPB[W-1]
                   : OPB[W-1])) && (alu_res[W-1] != OPA[W-1]));
        end
        else if (OP == cad_pkg::CAD_OP_SHL)
            alu_c = OP_BYTE ? OPA[7] : OPA[W-1];
        else if (OP == cad_pkg::CAD_OP_SHR || OP == cad_pkg::CAD_OP_ASR)
            alu_c = OPA[0];
        // byte write keeps the destination's upper byte, see RULE_08
        alu_wb = OP_BYTE ? {OPDST[W-1:8], alu_res[7:0]} : alu_res; // see RULE_06
    end

    ////////////////////////////////////////////////////////////////////////
    // engine: operand select, 17x17 multiply, 40-bit add/sub
    logic [W-1:0] m_x;
    logic [W-1:0] m_y;
    logic [AW-1:0] m_ext;
    logic [AW-1:0] acc_sel;
    logic [AW:0] acc_sum;
    logic [AW:0] acc_fin;
    logic acc_upd;
    logic sat_en;
    always_comb
    begin
        // dual-operand ops read registers four to seven directly
        m_x = OP_DUAL ? (OPA[0] ? WREG5 : WREG4) : XBUS_IN; // see RULE_13
        m_y = OP_DUAL ? (OPB[0] ? WREG7 : WREG6) : OPB; // see RULE_14
        mul_p = $signed({m_x[W-1], m_x}) * $signed({m_y[W-1], m_y}); // see RULE_12
        // mode bit set: integer; clear: fractional, one bit left
        if (ccw[`CAD_CCW_IF])
            m_ext = {{(AW-32){mul_p[31]}}, mul_p[31:0]}; // see RULE_20 RULE_21
        else
            m_ext = {{(AW-33){mul_p[31]}}, mul_p[31:0], 1'b0}; // see RULE_19
        prod_lo = mul_p[W-1:0];
        acc_sel = OP_ACC_B ? acc_b : acc_a;
        acc_upd = 1'b1;
        case (OP)
            cad_pkg::CAD_OP_MPY: acc_sum = {m_ext[AW-1], m_ext};
            cad_pkg::CAD_OP_MAC:
                acc_sum = {acc_sel[AW-1], acc_sel} + {m_ext[AW-1], m_ext};
            cad_pkg::CAD_OP_MSC:
                acc_sum = {acc_sel[AW-1], acc_sel} - {m_ext[AW-1], m_ext};
            // adds the other accumulator, no further operand needed
            cad_pkg::CAD_OP_ACCADD:
                acc_sum = {acc_a[AW-1], acc_a} + {acc_b[AW-1], acc_b}; // see RULE_16
            default:
            begin
                acc_sum = {acc_sel[AW-1], acc_sel};
                acc_upd = 1'b0;
            end
        endcase
        sat_en = OP_ACC_B ? ccw[`CAD_CCW_SATB] : ccw[`CAD_CCW_SATA];
        acc_fin = sat_en ? sat40(acc_sum) : acc_sum;
    end

    ////////////////////////////////////////////////////////////////////////
    // one instruction at a time: engine ops hold off integer issue
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            state <= cad_pkg::CAD_ST_IDLE;
            BUSY <= 1'b0;
        end
        else
        begin
            case (state)
                cad_pkg::CAD_ST_IDLE:
                    if (OP_VALID && acc_upd)
                    begin
                        state <= cad_pkg::CAD_ST_DSP; // see RULE_11
                        BUSY <= 1'b1;
                    end
                cad_pkg::CAD_ST_DSP:
                begin
                    state <= cad_pkg::CAD_ST_IDLE;
                    BUSY <= 1'b0;
                end
                default: state <= cad_pkg::CAD_ST_IDLE;
            endcase
        end
    end

    logic issue;
    assign issue = OP_VALID && (state == cad_pkg::CAD_ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // accumulators: engine results and register writes
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            acc_a <= '0;
            acc_b <= '0;
        end
        else if (issue && acc_upd)
        begin
            if (OP_ACC_B)
                acc_b <= acc_fin[AW-1:0]; // see RULE_15
            else
                acc_a <= acc_fin[AW-1:0];
        end
        else if (REG_WR)
        begin
            // three words per accumulator, guard byte in the low bits
            case (REG_ADDR)
                `CAD_ADR_AAL: acc_a[15:0] <= REG_WDATA; // see RULE_18
                `CAD_ADR_AAH: acc_a[31:16] <= REG_WDATA;
                `CAD_ADR_AAU: acc_a[39:32] <= REG_WDATA[7:0];
                `CAD_ADR_ABL: acc_b[15:0] <= REG_WDATA;
                `CAD_ADR_ABH: acc_b[31:16] <= REG_WDATA;
                `CAD_ADR_ABU: acc_b[39:32] <= REG_WDATA[7:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status word; a saturation event beats a software clear
    logic sat_hit;
    assign sat_hit = sat_en && (acc_sum[AW] != acc_sum[AW-1]);
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            psw <= '0;
        else
        begin
            if (REG_WR && REG_ADDR == `CAD_ADR_PSW)
                psw <= REG_WDATA;
            if (issue && alu_hit)
            begin
                psw[`CAD_PSW_C] <= alu_c; // see RULE_03
                psw[`CAD_PSW_Z] <= alu_z;
                psw[`CAD_PSW_N] <= alu_n;
                psw[`CAD_PSW_OV] <= alu_ov;
                psw[`CAD_PSW_DC] <= alu_dc;
            end
            if (issue && acc_upd)
            begin
                if (OP_ACC_B)
                begin
                    psw[`CAD_PSW_OB] <= guard_ovf(acc_fin[AW-1:0]); // see RULE_22
                    if (sat_hit)
                        psw[`CAD_PSW_SB] <= 1'b1; // see RULE_23
                end
                else
                begin
                    psw[`CAD_PSW_OA] <= guard_ovf(acc_fin[AW-1:0]);
                    if (sat_hit)
                        psw[`CAD_PSW_SA] <= 1'b1;
                end
            end
        end
    end

    // core control word, integer/fractional and saturation enables
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            ccw <= `CAD_CCW_RST;
        else if (REG_WR && REG_ADDR == `CAD_ADR_CCW)
            ccw <= REG_WDATA;
    end

    ////////////////////////////////////////////////////////////////////////
    // results to registers or the X bus
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            RES_VALID <= 1'b0;
            RES <= '0;
            XBUS_WR <= 1'b0;
            XBUS_OUT <= '0;
        end
        else
        begin
            RES_VALID <= issue && !acc_upd && OP != cad_pkg::CAD_OP_NOP;
            XBUS_WR <= issue && OP == cad_pkg::CAD_OP_SAC;
            XBUS_OUT <= acc_sel[31:16]; // see RULE_15
            case (OP)
                // sign extension ignores byte mode, always a full word
                cad_pkg::CAD_OP_SE: RES <= {{8{OPA[7]}}, OPA[7:0]}; // see RULE_09
                cad_pkg::CAD_OP_ZE: RES <= {8'h00, OPA[7:0]}; // see RULE_10
                cad_pkg::CAD_OP_SAC: RES <= acc_sel[31:16];
                default: RES <= alu_hit ? alu_wb : prod_lo; // see RULE_05
            endcase
        end
    end

    // register read data, one cycle after the strobe
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            REG_RDATA <= '0;
        else if (REG_RD)
            case (REG_ADDR)
                `CAD_ADR_AAL: REG_RDATA <= acc_a[15:0];
                `CAD_ADR_AAH: REG_RDATA <= acc_a[31:16];
                `CAD_ADR_AAU: REG_RDATA <= {8'h00, acc_a[39:32]};
                `CAD_ADR_ABL: REG_RDATA <= acc_b[15:0];
                `CAD_ADR_ABH: REG_RDATA <= acc_b[31:16];
                `CAD_ADR_ABU: REG_RDATA <= {8'h00, acc_b[39:32]};
                `CAD_ADR_PSW: REG_RDATA <= psw;
                `CAD_ADR_CCW: REG_RDATA <= ccw;
                default: REG_RDATA <= 16'h0000;
            endcase
        else
            REG_RDATA <= 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_byte_keep;
        @(posedge CLK) disable iff (RESET)
        issue && OP_BYTE && OP == cad_pkg::CAD_OP_ADD
        |=> RES[15:8] == $past(OPDST[15:8]);
    endproperty
    a_byte_keep: assert property (p_byte_keep) else $error("byte upper changed"); // see RULE_08
    property p_ze;
        @(posedge CLK) disable iff (RESET)
        issue && OP == cad_pkg::CAD_OP_ZE |=> RES[15:8] == 8'h00;
    endproperty
    a_ze: assert property (p_ze) else $error("zero extend bad"); // see RULE_10
    property p_se;
        @(posedge CLK) disable iff (RESET)
        issue && OP == cad_pkg::CAD_OP_SE |=> RES[15:8] == {8{RES[7]}};
    endproperty
    a_se: assert property (p_se) else $error("sign extend bad"); // see RULE_09
    property p_busy;
        @(posedge CLK) disable iff (RESET)
        issue && acc_upd |=> BUSY ##1 !BUSY;
    endproperty
    a_busy: assert property (p_busy) else $error("engine busy wrong"); // see RULE_11
    property p_sticky;
        @(posedge CLK) disable iff (RESET)
        psw[`CAD_PSW_SA] && !(REG_WR && REG_ADDR == `CAD_ADR_PSW)
        |=> psw[`CAD_PSW_SA];
    endproperty
    a_sticky: assert property (p_sticky) else $error("sat flag dropped"); // see RULE_23
    property p_zflag;
        @(posedge CLK) disable iff (RESET)
        issue && alu_hit && !OP_BYTE && !REG_WR
        |=> psw[`CAD_PSW_Z] == ($past(alu_res) == 16'h0000);
    endproperty
    a_zflag: assert property (p_zflag) else $error("zero flag wrong"); // see RULE_24
    property p_ovf;
        @(posedge CLK) disable iff (RESET)
        issue && acc_upd && !OP_ACC_B && !REG_WR
        |=> psw[`CAD_PSW_OA] == guard_ovf(acc_a);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag wrong"); // see RULE_22
    property p_rdzero;
        @(posedge CLK) disable iff (RESET)
        REG_RD && REG_ADDR == `CAD_ADR_AAU |=> REG_RDATA[15:8] == 8'h00;
    endproperty
    a_rdzero: assert property (p_rdzero) else $error("guard read high"); // see RULE_18
    c_mac: cover property (@(posedge CLK) issue && OP == cad_pkg::CAD_OP_MAC);
    c_sat: cover property (@(posedge CLK) issue && sat_hit);
    c_byte: cover property (@(posedge CLK) issue && OP_BYTE && alu_arith);
endmodule : cad_datapath
`default_nettype wire

// ### verif/cad_core_model.sv
// model of the decoder side: prefetched registers and the X bus
`timescale 1ns/1ps
`default_nettype none
module cad_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // loads from the bench
    input wire logic ld,
    input wire logic [2:0] ld_sel,
    input wire logic [15:0] ld_data,
    // engine side
    input wire logic xbus_wr,
    input wire logic [15:0] xbus_out,
    output logic [15:0] w4,
    output logic [15:0] w5,
    output logic [15:0] w6,
    output logic [15:0] w7,
    output logic [15:0] xbus_in,
    output logic [15:0] mem
);
    logic [15:0] r [0:4];
    // prefetch copies stay steady between loads, as the buses deliver them
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            r <= '{default: 16'h0000};
        else if (ld)
            r[ld_sel] <= ld_data;
    end
    // dual operand registers four to seven and the X bus word
    assign w4 = r[0];
    assign w5 = r[1];
    assign w6 = r[2];
    assign w7 = r[3];
    assign xbus_in = r[4];
    // data memory word stored by the engine over the X bus
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            mem <= 16'h0000;
        else if (xbus_wr)
            mem <= xbus_out;
    end
endmodule : cad_core_model
`default_nettype wire

// ### verif/cad_datapath_tb.sv
// self-checking bench for the core arithmetic datapath
`timescale 1ns/1ps
`default_nettype none
`include "cad_cfg.svh"
module cad_datapath_tb;
    typedef struct packed {logic [15:0] v; logic [15:0] m;} cad_note_t;
    logic clk = 1'h0, reset = 1'h1, op_valid = 1'h0, op_byte = 1'h0;
    logic op_acc_b = 1'h0, op_dual = 1'h0, rwr = 1'h0, rrd = 1'h0;
    logic ld = 1'h0, rd_pend = 1'h0;
    cad_pkg::cad_op_t op = cad_pkg::CAD_OP_NOP;
    logic [15:0] opa = 16'h0000, opb = 16'h0000, opdst = 16'h0000;
    logic [15:0] wdat = 16'h0000, ld_data = 16'h0000;
    logic [15:0] w4, w5, w6, w7, xin, res, xout, rdata;
    logic [15:0] wv [0:3];
    logic res_valid, xbus_wr, busy;
    logic [3:0] radr = 4'h0;
    logic [2:0] ld_sel = 3'h0;
    int err_count = 0;
    int n_tests = 0;
    int seed = 32'hDF35587E;
    cad_note_t q_res[$], q_rd[$], q_xb[$];
    // 25 MHz core clock
    always #20 clk = ~clk;
    cad_datapath uut (.CLK(clk), .RESET(reset), .OP_VALID(op_valid),
        .OP(op), .OP_BYTE(op_byte), .OP_ACC_B(op_acc_b), .OP_DUAL(op_dual),
        .OPA(opa), .OPB(opb), .OPDST(opdst), .WREG4(w4), .WREG5(w5),
        .WREG6(w6), .WREG7(w7), .XBUS_IN(xin), .RES_VALID(res_valid),
        .RES(res), .XBUS_WR(xbus_wr), .XBUS_OUT(xout), .BUSY(busy),
        .REG_ADDR(radr), .REG_WDATA(wdat), .REG_WR(rwr), .REG_RD(rrd),
        .REG_RDATA(rdata));
    cad_core_model partner (.clk(clk), .reset(reset), .ld(ld),
        .ld_sel(ld_sel), .ld_data(ld_data), .xbus_wr(xbus_wr),
        .xbus_out(xout), .w4(w4), .w5(w5), .w6(w6), .w7(w7),
        .xbus_in(xin), .mem());
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input cad_note_t e);
        n_tests++;
        if ((got & e.m) !== (e.v & e.m))
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, e.v);
        end
    endtask : check
    task automatic take(ref cad_note_t q[$], input logic [15:0] got);
        if (q.size() == 0)
            check(got, '{~got, 16'hFFFF}); // nothing expected: force a miss
        else
            check(got, q.pop_front());
    endtask : take
    // mid-cycle sampling keeps clear of the edge where outputs change
    always @(negedge clk)
    begin
        if (rd_pend)
            take(q_rd, rdata);
        if (res_valid === 1'h1)
            take(q_res, res);
        if (xbus_wr === 1'h1)
            take(q_xb, xout);
        rd_pend = rrd;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        radr <= a;
        wdat <= d;
        rwr <= 1'h1;
        @(posedge clk);
        rwr <= 1'h0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, input logic [15:0] v, m);
        @(posedge clk);
        radr <= a;
        rrd <= 1'h1;
        q_rd.push_back('{v, m});
        @(posedge clk);
        rrd <= 1'h0;
    endtask : reg_rd
    task automatic ld_w(input int i, input logic [15:0] v);
        wv[i] = v;
        @(posedge clk);
        ld_sel <= 3'(i);
        ld_data <= v;
        ld <= 1'h1;
        @(posedge clk);
        ld <= 1'h0;
    endtask : ld_w
    task automatic wr_acc(input logic b, input logic [39:0] v);
        reg_wr(b ? `CAD_ADR_ABL : `CAD_ADR_AAL, v[15:0]);
        reg_wr(b ? `CAD_ADR_ABH : `CAD_ADR_AAH, v[31:16]);
        reg_wr(b ? `CAD_ADR_ABU : `CAD_ADR_AAU, {8'h00, v[39:32]});
    endtask : wr_acc
    task automatic rd_acc(input logic b, input logic [39:0] v);
        reg_rd(b ? `CAD_ADR_ABL : `CAD_ADR_AAL, v[15:0], 16'hFFFF);
        reg_rd(b ? `CAD_ADR_ABH : `CAD_ADR_AAH, v[31:16], 16'hFFFF);
        reg_rd(b ? `CAD_ADR_ABU : `CAD_ADR_AAU, {8'h00, v[39:32]}, 16'h00FF);
    endtask : rd_acc
    // hold above one cycle re-presents the op while the engine is busy
    task automatic issue(input cad_pkg::cad_op_t o, input logic [15:0] a, b,
        d, input logic byt, accumulator_b, dual, input int hold);
        @(posedge clk);
        op <= o;
        opa <= a;
        opb <= b;
        opdst <= d;
        op_byte <= byt;
        op_acc_b <= accumulator_b;
        op_dual <= dual;
        op_valid <= 1'h1;
        repeat (hold) @(posedge clk);
        op_valid <= 1'h0;
    endtask : issue
    // integer result and flags; only carries and overflow of add/sub checked
    function automatic void exp_int(input cad_pkg::cad_op_t o,
        input logic [15:0] a, b, d, input logic byt,
        output cad_note_t rn, output cad_note_t fn);
        logic [15:0] r, bb;
        logic [16:0] s;
        logic [8:0] s8;
        logic [4:0] s4;
        logic ci, hi, ah, bh;
        ci = (o == cad_pkg::CAD_OP_SUB);
        bb = ci ? ~b : b;
        s = {1'h0, a} + {1'h0, bb} + 17'(ci);
        s8 = {1'h0, a[7:0]} + {1'h0, bb[7:0]} + 9'(ci);
        s4 = {1'h0, a[3:0]} + {1'h0, bb[3:0]} + 5'(ci);
        case (o)
            cad_pkg::CAD_OP_AND: r = a & b;
            cad_pkg::CAD_OP_IOR: r = a | b;
            cad_pkg::CAD_OP_XOR: r = a ^ b;
            cad_pkg::CAD_OP_SHL: r = {a[14:0], 1'h0};
            cad_pkg::CAD_OP_SHR: r = {1'h0, a[15:1]};
            cad_pkg::CAD_OP_ASR: r = {a[15], a[15:1]};
            cad_pkg::CAD_OP_SE: r = {{8{a[7]}}, a[7:0]};
            cad_pkg::CAD_OP_ZE: r = {8'h00, a[7:0]};
            default: r = s[15:0];
        endcase
        hi = byt ? r[7] : r[15];
        ah = byt ? a[7] : a[15];
        bh = byt ? bb[7] : bb[15];
        rn = '{byt ? {d[15:8], r[7:0]} : r, 16'hFFFF};
        fn = '{16'h0000, (o <= cad_pkg::CAD_OP_SUB) ? 16'h010F : 16'h000A};
        fn.v[`CAD_PSW_C] = byt ? s8[8] : s[16];
        fn.v[`CAD_PSW_DC] = byt ? s4[4] : s8[8];
        fn.v[`CAD_PSW_N] = hi;
        fn.v[`CAD_PSW_Z] = byt ? (r[7:0] == 8'h00) : (r == 16'h0000);
        fn.v[`CAD_PSW_OV] = (ah == bh) && (hi != ah);
    endfunction : exp_int
    task automatic summarize;
        if (q_res.size() + q_rd.size() + q_xb.size() != 0)
            err_count++;
        $display("counts: %0d checks, %0d errors", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////
    // watchdog against a hung run
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize();
    end
    // main sequence
    initial
    begin
        cad_note_t rn, fn;
        cad_pkg::cad_op_t o;
        logic [15:0] a, b, d;
        logic [39:0] p;
        logic byt, sa, sb;
        repeat (16) @(posedge clk);
        reset <= 1'h0;
        reg_rd(`CAD_ADR_CCW, `CAD_CCW_RST, 16'hFFFF);
        reg_rd(`CAD_ADR_PSW, 16'h0000, 16'hFFFF);
        reg_rd(4'hF, 16'h0000, 16'hFFFF);
        p = {8'($random(seed)), 32'($random(seed))};
        wr_acc(1'h1, p);
        rd_acc(1'h1, p);
        $display("test registers done");
        // every integer op in word width, add to xor also in byte width, random then boundary operands
        for (int i = 0; i < 50; i++)
        begin
            o = cad_pkg::cad_op_t'(i % 10);
            byt = (i % 20 >= 10) && o <= cad_pkg::CAD_OP_XOR;
            a = (i >= 40) ? {i[0], {15{~i[0]}}} : 16'($random(seed));
            b = (i >= 40) ? {{15{i[1]}}, ~i[1]} : 16'($random(seed));
            d = 16'($random(seed));
            exp_int(o, a, b, d, byt, rn, fn);
            q_res.push_back(rn);
            issue(o, a, b, d, byt, 1'h0, 1'h0, 1);
            reg_rd(`CAD_ADR_PSW, fn.v, fn.m);
        end
        $display("test integer done");
        // dual multiply into either accumulator, both modes, then store
        for (int k = 0; k < 4; k++)
        begin
            reg_wr(`CAD_ADR_CCW, {15'h0000, k[0]});
            for (int j = 0; j < 4; j++)
                ld_w(j, 16'($random(seed)));
            sa = 1'($random(seed));
            sb = 1'($random(seed));
            p = $signed(wv[sa]) * $signed(wv[2 + sb]);
            if (!k[0])
                p = p << 1;
            issue(cad_pkg::CAD_OP_MPY, {15'h0000, sa}, {15'h0000, sb},
                16'h0000, 1'h0, k[1], 1'h1, 1);
            @(negedge clk);
            check({15'h0000, busy}, '{16'h0001, 16'hFFFF});
            rd_acc(k[1], p);
            q_res.push_back('{p[31:16], 16'hFFFF});
            q_xb.push_back('{p[31:16], 16'hFFFF});
            issue(cad_pkg::CAD_OP_SAC, 16'h0000, 16'h0000, 16'h0000, 1'h0,
                k[1], 1'h0, 1);
        end
        $display("test multiply done");
        // guard overflow set and cleared, saturation flag held until cleared
        ld_w(0, 16'h0001);
        ld_w(2, 16'h0001);
        reg_wr(`CAD_ADR_CCW, 16'h0001);
        wr_acc(1'h0, 40'h007FFFFFFF);
        issue(cad_pkg::CAD_OP_MAC, 16'h0000, 16'h0000, 16'h0000, 1'h0, 1'h0,
            1'h1, 2);
        rd_acc(1'h0, 40'h0080000000);
        reg_rd(`CAD_ADR_PSW, 16'h8000, 16'h8000);
        issue(cad_pkg::CAD_OP_MSC, 16'h0000, 16'h0000, 16'h0000, 1'h0, 1'h0,
            1'h1, 1);
        rd_acc(1'h0, 40'h007FFFFFFF);
        reg_rd(`CAD_ADR_PSW, 16'h0000, 16'h8000);
        reg_wr(`CAD_ADR_CCW, 16'h0081);
        wr_acc(1'h0, 40'h7FFFFFFFFF);
        issue(cad_pkg::CAD_OP_MAC, 16'h0000, 16'h0000, 16'h0000, 1'h0, 1'h0,
            1'h1, 1);
        rd_acc(1'h0, 40'h7FFFFFFFFF);
        issue(cad_pkg::CAD_OP_MSC, 16'h0000, 16'h0000, 16'h0000, 1'h0, 1'h0,
            1'h1, 1);
        reg_rd(`CAD_ADR_PSW, 16'h2000, 16'h2000);
        reg_wr(`CAD_ADR_PSW, 16'h0000);
        reg_rd(`CAD_ADR_PSW, 16'h0000, 16'h2000);
        $display("test saturation done");
        repeat (4) @(posedge clk);
        summarize();
    end
endmodule : cad_datapath_tb
`default_nettype wire
